/* File: rtl/ram_fifo_defs.svh */
// constants for the ram fifo bus-cycle unit
`ifndef RAM_FIFO_DEFS_SVH
`define RAM_FIFO_DEFS_SVH

`define PTR_W 12
`define ADDR_W 24
`define DATA_W 8
`define SIZE_SEL_W 3
// fifo size is min size shifted left by the size select field
`define FIFO_MIN_SIZE 12'h010
`define PTR_RESET 12'h000
`define ADDR_RESET 24'h000000
`define DATA_RESET 8'h00
// timing: clock period in ns, cycle lengths in system clock states
`define SYS_CLK_PERIOD_NS 100
`define BUS_CYCLE_STATES 2
`define ISSUE_STATES 1

`endif

/* File: rtl/ram_fifo_pkg.sv */
// types shared by the ram fifo bus-cycle unit
`include "ram_fifo_defs.svh"

package ram_fifo_pkg;

  typedef enum logic [1:0] {
    REQ_TRANSFER = 2'h0,
    REQ_MARK = 2'h1,
    REQ_RELOAD = 2'h2,
    REQ_RESET = 2'h3
  } req_kind_type;

  typedef enum logic [1:0] {
    TEMP_UNUSED = 2'h0,
    TEMP_READ = 2'h1,
    TEMP_WRITE = 2'h2
  } temp_mode_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ISSUE = 6'h02,
    ST_WAIT = 6'h04,
    ST_T1 = 6'h08,
    ST_T2 = 6'h10,
    ST_RESP = 6'h20
  } cycle_state_type;

  typedef struct packed {
    cycle_state_type state;
    logic armed;
    req_kind_type kind;
    logic ram_to_periph;
    logic err;
    logic [`PTR_W-1:0] read_pointer;
    logic [`PTR_W-1:0] write_pointer;
    logic [`PTR_W-1:0] temporary_pointer;
    logic [`ADDR_W-1:0] ram_addr;
    logic ram_rd;
    logic ram_wr;
    logic [`DATA_W-1:0] ram_wdata;
    logic periph_rd;
    logic periph_wr;
    logic [`DATA_W-1:0] periph_wdata;
    logic ack;
    logic empty;
    logic full;
    logic overread;
    logic overwrite;
    logic high_speed_req;
  } unit_state_type;

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_type;

endpackage

/* File: rtl/request_sync.sv */
// two-stage synchronizer for the peripheral request level
`timescale 1ns/1ps
`default_nettype none

module request_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request level from the peripheral side
  input wire logic req_async,
  // request level in the system clock domain
  output logic req_sync
);
  import ram_fifo_pkg::*;

  sync_state_type s_r;
  sync_state_type s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt.meta = req_async;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_sync = s_r.sync;

endmodule

`default_nettype wire

/* File: rtl/ram_fifo_unit.sv */
// ram fifo bus-cycle unit: serves peripheral byte requests through a ring buffer in ram
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.svh"

module ram_fifo_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // peripheral request
  input wire logic periph_req,
  input wire ram_fifo_pkg::req_kind_type req_kind,
  input wire logic req_ram_to_periph,
  input wire logic periph_tick,
  // configuration
  input wire logic [`ADDR_W-1:0] fifo_base,
  input wire logic [`SIZE_SEL_W-1:0] fifo_size_sel,
  input wire ram_fifo_pkg::temp_mode_type temp_mode,
  input wire logic bus_divide_enable,
  input wire logic fast_clock_override,
  input wire logic medium_speed_active,
  // bus slot conditions
  input wire logic bus_break,
  input wire logic cpu_internal_cycle,
  input wire logic cpu_cycle_end,
  input wire logic cpu_word_upper,
  input wire logic cpu_long_upper,
  input wire logic cpu_sequence_cycle,
  input wire logic ctl_cycle_end,
  input wire logic ctl_word_upper,
  input wire logic ctl_vector_read,
  input wire logic ctl_reg_partial,
  // cpu store to the write pointer
  input wire logic write_pointer_load,
  input wire logic [`PTR_W-1:0] write_pointer_value,
  // ram side
  output logic [`ADDR_W-1:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [`DATA_W-1:0] ram_wdata,
  input wire logic [`DATA_W-1:0] ram_rdata,
  // peripheral data
  output logic periph_rd,
  output logic periph_wr,
  output logic [`DATA_W-1:0] periph_wdata,
  input wire logic [`DATA_W-1:0] periph_rdata,
  // response and status
  output logic ack,
  output logic fifo_empty,
  output logic fifo_full,
  output logic overread,
  output logic overwrite,
  output logic high_speed_req,
  // pointer state
  output logic [`PTR_W-1:0] read_pointer,
  output logic [`PTR_W-1:0] write_pointer,
  output logic [`PTR_W-1:0] temporary_pointer
);
  import ram_fifo_pkg::*;

  unit_state_type s_r;
  unit_state_type s_nxt;
  logic req_sync;
  logic slot_end;
  logic insert_ok;
  logic speed_ok;
  logic [`PTR_W-1:0] adv_ptr;

  function automatic logic [`PTR_W-1:0] fifo_size(input logic [`SIZE_SEL_W-1:0] sel);
    fifo_size = `FIFO_MIN_SIZE << sel;
  endfunction

  // wrap keeps the ring inside the configured size
  function automatic logic [`PTR_W-1:0] ptr_advance(input logic [`PTR_W-1:0] p,
                                                     input logic [`SIZE_SEL_W-1:0] sel);
    logic [`PTR_W-1:0] sum;
    sum = p + `PTR_W'(1);
    // sizes are powers of two, so the remainder is a mask; also folds a pointer left from a larger size
    ptr_advance = sum & (fifo_size(sel) - `PTR_W'(1));
  endfunction

  function automatic logic [`ADDR_W-1:0] ram_address(input logic [`ADDR_W-1:0] base,
                                                      input logic [`PTR_W-1:0] p);
    ram_address = base + {{(`ADDR_W-`PTR_W){1'b0}}, p};
  endfunction

  request_sync u_req_sync (
    .mclk(mclk),
    .reset(reset),
    .req_async(periph_req),
    .req_sync(req_sync)
  );

  // bus slot qualification
  always_comb begin
    slot_end = bus_break || cpu_internal_cycle || cpu_cycle_end || ctl_cycle_end;
    insert_ok = slot_end;
    if (cpu_word_upper || ctl_word_upper) begin
      insert_ok = 1'b0;
    end else if (ctl_vector_read || ctl_reg_partial) begin
      insert_ok = 1'b0;
    end else if (!bus_divide_enable && (cpu_long_upper || cpu_sequence_cycle)) begin
      insert_ok = 1'b0;
    end else if (bus_divide_enable && (cpu_long_upper || cpu_sequence_cycle)) begin
      insert_ok = 1'b1;
    end
    speed_ok = !medium_speed_active || fast_clock_override;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ram_rd = 1'b0;
    s_nxt.ram_wr = 1'b0;
    s_nxt.periph_rd = 1'b0;
    s_nxt.periph_wr = 1'b0;
    adv_ptr = s_r.ram_to_periph ? ptr_advance(s_r.read_pointer, fifo_size_sel)
                                : ptr_advance(s_r.write_pointer, fifo_size_sel);
    if (!req_sync) begin
      s_nxt.armed = 1'b1;
    end
    // cpu pointer store only between cycles, so a running cycle never sees it move
    if (write_pointer_load && s_r.state == ST_IDLE) begin
      s_nxt.write_pointer = write_pointer_value;
    end
    case (s_r.state)
      ST_IDLE: begin
        // a request still high from the last answer is not taken twice
        if (req_sync && s_r.armed) begin
          s_nxt.armed = 1'b0;
          s_nxt.kind = req_kind;
          s_nxt.ram_to_periph = req_ram_to_periph;
          s_nxt.high_speed_req = 1'b1;
          s_nxt.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        s_nxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (insert_ok && speed_ok) begin
          s_nxt.state = ST_T1;
          s_nxt.err = 1'b0;
          if (s_r.kind == REQ_TRANSFER) begin
            // equal pointers on entry: refuse the byte, keep pointers
            if (s_r.read_pointer == s_r.write_pointer) begin
              s_nxt.err = 1'b1;
            end else if (s_r.ram_to_periph) begin
              s_nxt.ram_addr = ram_address(fifo_base, s_r.read_pointer);
              s_nxt.ram_rd = 1'b1;
            end else begin
              s_nxt.ram_addr = ram_address(fifo_base, s_r.write_pointer);
              s_nxt.periph_rd = 1'b1;
            end
          end
        end
      end
      ST_T1: begin
        s_nxt.state = ST_T2;
        s_nxt.ack = 1'b1;
        case (s_r.kind)
          REQ_TRANSFER: begin
            if (s_r.err) begin
              s_nxt.overread = s_r.ram_to_periph;
              s_nxt.overwrite = !s_r.ram_to_periph;
            end else if (s_r.ram_to_periph) begin
              s_nxt.periph_wdata = ram_rdata;
              s_nxt.periph_wr = 1'b1;
              s_nxt.read_pointer = adv_ptr;
              s_nxt.empty = (adv_ptr == s_r.write_pointer);
            end else begin
              s_nxt.ram_wdata = periph_rdata;
              s_nxt.ram_wr = 1'b1;
              s_nxt.write_pointer = adv_ptr;
              s_nxt.full = (adv_ptr == s_r.read_pointer);
            end
          end
          REQ_MARK: begin
            if (temp_mode == TEMP_READ) begin
              s_nxt.temporary_pointer = s_r.read_pointer;
            end else if (temp_mode == TEMP_WRITE) begin
              s_nxt.temporary_pointer = s_r.write_pointer;
            end
          end
          REQ_RELOAD: begin
            if (temp_mode == TEMP_READ) begin
              s_nxt.read_pointer = s_r.temporary_pointer;
            end else if (temp_mode == TEMP_WRITE) begin
              s_nxt.write_pointer = s_r.temporary_pointer;
            end
          end
          default: begin
            s_nxt.read_pointer = `PTR_RESET;
            s_nxt.write_pointer = `PTR_RESET;
            s_nxt.temporary_pointer = `PTR_RESET;
          end
        endcase
      end
      ST_T2: begin
        s_nxt.high_speed_req = 1'b0;
        if (periph_tick) begin
          s_nxt.state = ST_IDLE;
          s_nxt.ack = 1'b0;
          s_nxt.empty = 1'b0;
          s_nxt.full = 1'b0;
          s_nxt.overread = 1'b0;
          s_nxt.overwrite = 1'b0;
        end else begin
          s_nxt.state = ST_RESP;
        end
      end
      ST_RESP: begin
        // answer stands until the peripheral clock has seen it
        if (periph_tick) begin
          s_nxt.state = ST_IDLE;
          s_nxt.ack = 1'b0;
          s_nxt.empty = 1'b0;
          s_nxt.full = 1'b0;
          s_nxt.overread = 1'b0;
          s_nxt.overwrite = 1'b0;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.kind <= REQ_TRANSFER;
      s_r.read_pointer <= `PTR_RESET;
      s_r.write_pointer <= `PTR_RESET;
      s_r.temporary_pointer <= `PTR_RESET;
      s_r.ram_addr <= `ADDR_RESET;
      s_r.ram_wdata <= `DATA_RESET;
      s_r.periph_wdata <= `DATA_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ram_addr = s_r.ram_addr;
  assign ram_rd = s_r.ram_rd;
  assign ram_wr = s_r.ram_wr;
  assign ram_wdata = s_r.ram_wdata;
  assign periph_rd = s_r.periph_rd;
  assign periph_wr = s_r.periph_wr;
  assign periph_wdata = s_r.periph_wdata;
  assign ack = s_r.ack;
  assign fifo_empty = s_r.empty;
  assign fifo_full = s_r.full;
  assign overread = s_r.overread;
  assign overwrite = s_r.overwrite;
  assign high_speed_req = s_r.high_speed_req;
  assign read_pointer = s_r.read_pointer;
  assign write_pointer = s_r.write_pointer;
  assign temporary_pointer = s_r.temporary_pointer;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_enter_cycle;
    (s_r.state == ST_WAIT) ##1 (s_r.state == ST_T1);
  endsequence

  sequence s_full_cycle;
    (s_r.state == ST_T1) ##1 (s_r.state == ST_T2);
  endsequence

  a_cycle_two_states: assert property (s_enter_cycle |=> (s_r.state == ST_T2) ##1 (s_r.state != ST_T1))
    else $error("bus cycle did not last two states");

  a_ack_with_cycle: assert property (s_full_cycle |-> ack && $past(!ack))
    else $error("acknowledge missing at second state");

  a_no_split_word: assert property (s_enter_cycle |-> $past(!cpu_word_upper && !ctl_word_upper, 1))
    else $error("cycle inserted inside divided word access");

  a_ctl_partial_block: assert property (s_enter_cycle |-> $past(!ctl_vector_read && !ctl_reg_partial, 1))
    else $error("cycle inserted after controller vector or partial register read");

  a_speed_gate: assert property (s_enter_cycle |-> $past(speed_ok, 1) && high_speed_req)
    else $error("cycle ran on divided clock");

  a_overread_hold: assert property (
    (s_r.state == ST_T1 && s_r.kind == REQ_TRANSFER && s_r.err && s_r.ram_to_periph)
    |=> overread && !periph_wr && $stable(read_pointer) && $stable(write_pointer))
    else $error("overread moved data or pointers");

  a_overwrite_hold: assert property (
    (s_r.state == ST_T1 && s_r.kind == REQ_TRANSFER && s_r.err && !s_r.ram_to_periph)
    |=> overwrite && !ram_wr && $stable(write_pointer))
    else $error("overwrite moved data or pointers");

  a_read_advance: assert property ((s_r.state == ST_T1 && ram_rd)
    |=> periph_wr && read_pointer == ptr_advance($past(read_pointer), fifo_size_sel))
    else $error("read transfer did not advance the read pointer");

  a_ram_address: assert property ((s_r.state == ST_T1 && (ram_rd || periph_rd))
    |-> ram_addr == ram_address($past(fifo_base), s_r.ram_to_periph ? read_pointer : write_pointer))
    else $error("ram address is not base plus pointer");

  a_empty_equal: assert property ($rose(fifo_empty) |-> read_pointer == write_pointer && periph_wr)
    else $error("empty flagged with unequal pointers");

  a_full_equal: assert property ($rose(fifo_full) |-> write_pointer == read_pointer && ram_wr)
    else $error("full flagged with unequal pointers");

  a_reset_clears: assert property ((s_r.state == ST_T1 && s_r.kind == REQ_RESET)
    |=> read_pointer == `PTR_RESET && write_pointer == `PTR_RESET && temporary_pointer == `PTR_RESET)
    else $error("pointer reset left a pointer nonzero");

  // reloads may bring back a pointer marked under a larger size, so only read-pointer advances are held to the range
  a_ptr_wrap: assert property (
    (s_r.state == ST_T2 && s_r.kind == REQ_TRANSFER && s_r.ram_to_periph && !s_r.err && $stable(fifo_size_sel))
    |-> read_pointer < fifo_size(fifo_size_sel))
    else $error("read pointer left the fifo range");

  a_resp_release: assert property ((ack && periph_tick) |=> !ack ##1 (s_r.state != ST_T1))
    else $error("response not released after peripheral tick");

endmodule

`default_nettype wire

/* File: verification/periph_ram_model.sv */
// peripheral and ram stand-in facing the ram fifo unit
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.svh"

module periph_ram_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // ram side
  input wire logic [`ADDR_W-1:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [`DATA_W-1:0] ram_wdata,
  output logic [`DATA_W-1:0] ram_rdata,
  // peripheral side
  input wire logic periph_rd,
  input wire logic periph_wr,
  input wire logic [`DATA_W-1:0] periph_wdata,
  output logic [`DATA_W-1:0] periph_rdata,
  output logic periph_tick
);
  logic [`DATA_W-1:0] mem [256];
  logic [`DATA_W-1:0] hold_r;
  logic [2:0] phase_r;

  // data not strobed shows a moving pattern, so a stale byte never looks valid
  assign ram_rdata = ram_rd ? mem[ram_addr[7:0]] : ~hold_r;
  assign periph_rdata = periph_rd ? hold_r : ({5'h00, phase_r} ^ 8'ha5);
  // slow peripheral clock: samples after one or two states
  assign periph_tick = phase_r[0] | phase_r[2];

  initial begin
    hold_r = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  end

  always @(posedge mclk) begin
    phase_r <= reset ? 3'h0 : phase_r + 3'h1;
    if (ram_wr) mem[ram_addr[7:0]] <= ram_wdata;
    if (periph_wr) hold_r <= periph_wdata;
    else if (!periph_rd) hold_r <= hold_r + 8'h3b;
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the ram fifo bus-cycle unit
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.svh"

module tb;
  import ram_fifo_pkg::*;
  // slot opens at once: the system runs expansion accesses as three states with no waits
  localparam logic [9:0] BB = 10'h200;
  // {slot opens, divide enable, slot vector}; blocked cases carry a slot end so only the blocking rule holds them
  localparam logic [11:0] CASES [12] = '{12'ha00, 12'h900, 12'h880, 12'h808, 12'h6c0, 12'h60c,
    12'h60a, 12'h609, 12'h0a0, 12'hc20, 12'h090, 12'hc10};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic periph_req = 1'b0;
  req_kind_type req_kind = REQ_TRANSFER;
  logic req_ram_to_periph = 1'b0;
  logic [`ADDR_W-1:0] fifo_base = 24'h000000;
  logic [`SIZE_SEL_W-1:0] fifo_size_sel = 3'h0;
  temp_mode_type temp_mode = TEMP_UNUSED;
  logic bus_divide_enable = 1'b0;
  logic fast_clock_override = 1'b0;
  logic medium_speed_active = 1'b0;
  logic [9:0] slot = BB;
  logic write_pointer_load = 1'b0;
  logic [`PTR_W-1:0] write_pointer_value = 12'h000;
  logic [`ADDR_W-1:0] ram_addr;
  logic ram_rd, ram_wr, periph_rd, periph_wr, periph_tick, ack;
  logic fifo_empty, fifo_full, overread, overwrite, high_speed_req;
  logic [`DATA_W-1:0] ram_wdata, ram_rdata, periph_wdata, periph_rdata;
  logic [`PTR_W-1:0] read_pointer, write_pointer, temporary_pointer;
  logic [`PTR_W-1:0] rp = 12'h000, wp = 12'h000, tp = 12'h000;
  int fails = 0, checks = 0, cycles = 0, strobes = 0;
  int moves = 0;
  logic [1:0] exp_move = 2'b00;
  logic [`ADDR_W-1:0] exp_addr = 24'h000000;
  logic [`DATA_W-1:0] ram_byte = 8'h00, periph_byte = 8'h00;

  ram_fifo_unit ram_fifo_unit_inst (
    .mclk, .reset, .periph_req, .req_kind, .req_ram_to_periph, .periph_tick,
    .fifo_base, .fifo_size_sel, .temp_mode, .bus_divide_enable, .fast_clock_override,
    .medium_speed_active, .bus_break(slot[9]), .cpu_internal_cycle(slot[8]),
    .cpu_cycle_end(slot[7]), .cpu_word_upper(slot[6]), .cpu_long_upper(slot[5]),
    .cpu_sequence_cycle(slot[4]), .ctl_cycle_end(slot[3]), .ctl_word_upper(slot[2]),
    .ctl_vector_read(slot[1]), .ctl_reg_partial(slot[0]), .write_pointer_load, .write_pointer_value,
    .ram_addr, .ram_rd, .ram_wr,
    .ram_wdata, .ram_rdata, .periph_rd, .periph_wr, .periph_wdata, .periph_rdata, .ack,
    .fifo_empty, .fifo_full, .overread, .overwrite, .high_speed_req, .read_pointer,
    .write_pointer, .temporary_pointer
  );

  periph_ram_model periph_ram_model_inst (
    .mclk, .reset, .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .periph_rd,
    .periph_wr, .periph_wdata, .periph_rdata, .periph_tick
  );

  always #50 mclk = ~mclk;

  // hang guard; strobe cycles are held against the moves the model predicts
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (ram_rd | ram_wr | periph_rd | periph_wr) strobes <= strobes + 1;
    // bytes the partner offered while the unit strobed it
    if (ram_rd) ram_byte <= ram_rdata;
    if (periph_rd) periph_byte <= periph_rdata;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // pointer model; returns {empty, full, overread, overwrite}
  function automatic logic [3:0] predict(input req_kind_type k, input logic dir);
    logic [`PTR_W-1:0] size;
    size = `FIFO_MIN_SIZE << fifo_size_sel;
    predict = 4'h0;
    exp_move = 2'b00;
    exp_addr = fifo_base + {12'h000, (dir ? rp : wp)};
    case (k)
      REQ_TRANSFER: begin
        if (rp == wp) predict = {2'b00, dir, ~dir};
        else if (dir) begin
          exp_move = 2'b10;
          moves++;
          rp = (rp + 12'h001) % size;
          predict = {rp == wp, 3'b000};
        end else begin
          exp_move = 2'b01;
          moves++;
          wp = (wp + 12'h001) % size;
          predict = {1'b0, wp == rp, 2'b00};
        end
      end
      REQ_MARK: tp = (temp_mode == TEMP_READ) ? rp : ((temp_mode == TEMP_WRITE) ? wp : tp);
      REQ_RELOAD: begin
        if (temp_mode == TEMP_READ) rp = tp;
        if (temp_mode == TEMP_WRITE) wp = tp;
      end
      default: begin
        rp = 12'h000;
        wp = 12'h000;
        tp = 12'h000;
      end
    endcase
  endfunction

  // one request, entered just after an edge; ok low means it must wait for a slot or speed
  task automatic request(input req_kind_type k, input logic dir, input logic [9:0] sl, input logic ok);
    int n;
    logic [3:0] est;
    est = predict(k, dir);
    slot = sl;
    req_kind = k;
    req_ram_to_periph = dir;
    periph_req = 1'b1;
    n = 0;
    while (ack !== 1'b1 && n < 16) begin
      @(posedge mclk) #1;
      n++;
    end
    if (!ok) begin
      chk("blocked_ack", ack, 1'b0);
      chk("high_speed", high_speed_req, 1'b1);
      slot = BB;
      fast_clock_override = 1'b1;
      n = 0;
      while (ack !== 1'b1 && n < 8) begin
        @(posedge mclk) #1;
        n++;
      end
      chk("release_time", n <= 4, 1'b1);
    end else begin
      chk("latency", n >= 5 && n <= 11, 1'b1);
    end
    chk("ack", ack, 1'b1);
    chk("status", {fifo_empty, fifo_full, overread, overwrite}, est);
    chk("read_pointer", read_pointer, rp);
    chk("write_pointer", write_pointer, wp);
    chk("temporary_pointer", temporary_pointer, tp);
    chk("periph_wr", periph_wr, exp_move[1]);
    chk("ram_wr", ram_wr, exp_move[0]);
    if (exp_move != 2'b00) chk("ram_addr", ram_addr, exp_addr);
    if (exp_move[1]) chk("periph_wdata", periph_wdata, ram_byte);
    if (exp_move[0]) chk("ram_wdata", ram_wdata, periph_byte);
    periph_req = 1'b0;
    n = 0;
    while (ack === 1'b1 && n < 4) begin
      @(posedge mclk) #1;
      n++;
    end
    chk("ack_hold", n <= 2, 1'b1);
    // request level must be seen low through the synchronizer before the next one
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // cpu store to the write pointer, made while the unit is idle
  task automatic load_wp(input logic [`PTR_W-1:0] v);
    write_pointer_value = v;
    write_pointer_load = 1'b1;
    @(posedge mclk) #1;
    write_pointer_load = 1'b0;
    wp = v;
  endtask

  initial begin
    int n;
    n = $urandom(32'hc5e0c70d);
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("reset_pointers", {read_pointer, write_pointer}, 24'h000000);
    request(REQ_RESET, 1'b0, BB, 1'b1);
    request(REQ_TRANSFER, 1'b1, BB, 1'b1);
    request(REQ_TRANSFER, 1'b0, BB, 1'b1);
    for (int m = 0; m < 3; m++) begin
      temp_mode = temp_mode_type'(m);
      request(REQ_MARK, 1'b0, BB, 1'b1);
      request(REQ_RELOAD, 1'b0, BB, 1'b1);
    end
    load_wp(12'h00d);
    for (int i = 0; i < 4; i++) request(REQ_TRANSFER, 1'b0, BB, 1'b1);
    load_wp(12'h005);
    for (int i = 0; i < 6; i++) request(REQ_TRANSFER, 1'b1, BB, 1'b1);
    load_wp(12'h00f);
    for (int i = 0; i < 12; i++) begin
      bus_divide_enable = CASES[i][10];
      request(REQ_TRANSFER, 1'b1, CASES[i][9:0], CASES[i][11]);
    end
    medium_speed_active = 1'b1;
    fast_clock_override = 1'b0;
    request(REQ_MARK, 1'b0, BB, 1'b0);
    for (int i = 0; i < 40; i++) begin
      if (i % 4 == 0) load_wp(12'($urandom));
      fifo_base = 24'($urandom);
      fifo_size_sel = 3'($urandom);
      temp_mode = temp_mode_type'($urandom_range(2));
      bus_divide_enable = 1'($urandom);
      medium_speed_active = 1'($urandom);
      fast_clock_override = 1'($urandom);
      request(req_kind_type'($urandom_range(3)), 1'($urandom), BB,
              ~(medium_speed_active & ~fast_clock_override));
    end
    chk("strobes", strobes[23:0], 24'(moves * 2));
    end_sim();
  end
endmodule
`default_nettype wire
